/* hw/dao_regs.svh */
// Register offsets, reset values and timing counts of the dual converter output block
`ifndef DAO_REGS_SVH
`define DAO_REGS_SVH

// Register byte offsets (haddr[7:0])
`define DAO_OFF_CTRL 8'h00
`define DAO_OFF_STATUS 8'h04
`define DAO_OFF_RESULT 8'h08
`define DAO_OFF_INT_STAT 8'h0c
`define DAO_OFF_INT_EN 8'h10
`define DAO_OFF_INT_CLR 8'h14
`define DAO_OFF_COUNT 8'h18

// Reset values
`define DAO_CTRL_RST 2'h3
`define DAO_INT_EN_RST 4'h0

// Pipeline depth in sample clock periods
`define DAO_LATENCY 3'h6

// Valid signed input span of the converter core
`define DAO_LEVEL_MAX 12'sh1ff
`define DAO_LEVEL_MIN 12'she00

// Four levels of the shared format pin
`define DAO_FMT_GND 2'h0
`define DAO_FMT_THIRD 2'h1
`define DAO_FMT_TWO_THIRD 2'h2
`define DAO_FMT_SUPPLY 2'h3

`endif

/* hw/dao_pkg.sv */
// Types shared by the dual converter output block
`include "dao_regs.svh"

package dao_pkg;

    // Gray along normal -> hiz -> nap -> sleep
    typedef enum logic [1:0] {
        DAO_NORMAL = 2'h0,
        DAO_HIZ = 2'h1,
        DAO_NAP = 2'h3,
        DAO_SLEEP = 2'h2
    } dao_mode_t;

    typedef struct packed {
        logic clk_prev;
        logic [11:0] held;
        logic [`DAO_LATENCY-1:0][10:0] pipe;
        logic [2:0] fill;
        dao_mode_t mode;
        logic new_result;
    } dao_chan_st_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [1:0] ctrl;
        logic [3:0] int_stat;
        logic [3:0] int_en;
        logic irq;
        logic twos;
        logic stab;
        logic [9:0] bus_a_result;
        logic bus_a_flag;
        logic bus_a_oe_n;
        logic [9:0] bus_b_result;
        logic bus_b_flag;
        logic bus_b_oe_n;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
    } dao_top_st_t;

endpackage

/* hw/dao_chan_if.sv */
// Control and result signals between the top and one converter channel
`timescale 1ns/1ps
`default_nettype none

interface dao_chan_if;
    logic sample_clock;
    logic power_down_sel;
    logic output_enable_n;
    logic capture_en;
    logic twos;
    logic [11:0] level;
    logic [9:0] result;
    logic range_flag;
    logic hiz;
    logic new_result;
    dao_pkg::dao_mode_t mode;

    modport chan (
        input sample_clock,
        input power_down_sel,
        input output_enable_n,
        input capture_en,
        input twos,
        input level,
        output result,
        output range_flag,
        output hiz,
        output new_result,
        output mode
    );

    modport ctl (
        output sample_clock,
        output power_down_sel,
        output output_enable_n,
        output capture_en,
        output twos,
        output level,
        input result,
        input range_flag,
        input hiz,
        input new_result,
        input mode
    );
endinterface

`default_nettype wire

/* hw/dao_chan.sv */
// One converter channel: sample hold, six-stage pipeline, output coding, power modes
`timescale 1ns/1ps
`default_nettype none
`include "dao_regs.svh"

module dao_chan (
    input wire logic hclk,
    input wire logic hresetn,
    dao_chan_if.chan ch
);

    dao_pkg::dao_chan_st_t st;
    dao_pkg::dao_chan_st_t next_st;
    logic rise;

    // Clamp to the core span, flag the overrange, then apply the coding
    function automatic logic [10:0] dao_convert(input logic signed [11:0] lvl,
                                                input logic twos);
        logic signed [11:0] c;
        logic flag;
        flag = (lvl > `DAO_LEVEL_MAX) || (lvl < `DAO_LEVEL_MIN);
        c = flag ? ((lvl > `DAO_LEVEL_MAX) ? `DAO_LEVEL_MAX : `DAO_LEVEL_MIN) : lvl;
        // Straight binary is the two's complement word with its top bit inverted
        return {flag, twos ? c[9:0] : {~c[9], c[8:0]}};
    endfunction

    assign rise = ch.sample_clock & ~st.clk_prev;

    always_comb begin
        next_st = st;
        next_st.new_result = 1'b0;
        next_st.clk_prev = ch.sample_clock;
        unique case ({ch.power_down_sel, ch.output_enable_n})
            2'b00: next_st.mode = dao_pkg::DAO_NORMAL;
            2'b01: next_st.mode = dao_pkg::DAO_HIZ;
            2'b10: next_st.mode = dao_pkg::DAO_NAP;
            2'b11: next_st.mode = dao_pkg::DAO_SLEEP;
        endcase
        if (rise && ch.capture_en && !ch.power_down_sel) begin
            // Input frozen at the rising instant, converted on the next edge
            next_st.held = ch.level;
            next_st.pipe = {st.pipe[`DAO_LATENCY-2:0], dao_convert(st.held, ch.twos)};
            if (st.fill != `DAO_LATENCY) begin
                next_st.fill = st.fill + 3'h1;
            end
            // The first push after wake carries a stale hold, so only a full pipe yields a sample
            next_st.new_result = (st.fill == `DAO_LATENCY);
        end
        // Sleep loses the pipeline; nap keeps it so wake-up output resumes at once
        if (next_st.mode == dao_pkg::DAO_SLEEP) begin
            next_st.fill = 3'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.mode <= dao_pkg::DAO_SLEEP;
        end else begin
            st <= next_st;
        end
    end

    assign ch.result = st.pipe[`DAO_LATENCY-1][9:0];
    assign ch.range_flag = st.pipe[`DAO_LATENCY-1][10];
    assign ch.hiz = (st.mode != dao_pkg::DAO_NORMAL);
    assign ch.new_result = st.new_result;
    assign ch.mode = st.mode;

endmodule

`default_nettype wire

/* hw/dao_top.sv */
// Top of the dual converter output block: bus steering, format pin, AHB-Lite registers
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dao_regs.svh"

// Functional notes
// - Each channel starts a new sample on the rising edge of its own sample clock.
// - With bus steering high, channel A drives bus A and channel B drives bus B.
// - With bus steering low, the buses swap: channel A on bus B, channel B on bus A.
// - Power-down low and output enable low: convert and drive the bus.
// - Power-down low and output enable high: convert but float the bus.
// - Power-down high and output enable low: nap, bus floating.
// - Power-down high and output enable high: sleep, bus floating.
// - Each result is a 10-bit word with bit 9 the most significant.
// - The range flag is high when the input was above or below the span.
// - One four-level format pin sets coding and stabilizer for both channels.
// - A sample appears on the bus six sample clock periods after it was taken.
// - The input is tracked while the clock is low and held when it rises.
module dao_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic chan_a_sample_clock,
    input wire logic chan_b_sample_clock,
    input wire logic [11:0] chan_a_level,
    input wire logic [11:0] chan_b_level,
    input wire logic chan_a_power_down_sel,
    input wire logic chan_b_power_down_sel,
    input wire logic chan_a_output_enable_n,
    input wire logic chan_b_output_enable_n,
    input wire logic bus_steer,
    input wire logic [1:0] format_level,
    output logic [9:0] bus_a_result,
    output logic chan_a_range_flag,
    output logic bus_a_oe_n,
    output logic [9:0] bus_b_result,
    output logic chan_b_range_flag,
    output logic bus_b_oe_n,
    output logic stabilizer_on
);

    dao_pkg::dao_top_st_t st;
    dao_pkg::dao_top_st_t next_st;
    dao_chan_if ch_a();
    dao_chan_if ch_b();
    logic addr_ok;
    logic [3:0] events;
    logic [3:0] clr;

    // Format pin levels: {two's complement, stabilizer on}
    function automatic logic [1:0] dao_fmt_decode(input logic [1:0] lvl);
        logic [1:0] r;
        r = 2'h0;
        unique case (lvl)
            `DAO_FMT_GND: r = 2'b00;
            `DAO_FMT_THIRD: r = 2'b01;
            `DAO_FMT_TWO_THIRD: r = 2'b11;
            `DAO_FMT_SUPPLY: r = 2'b10;
        endcase
        return r;
    endfunction

    // Read side of the register map; unmapped and write-only offsets read zero
    function automatic logic [31:0] dao_read(input logic [7:0] a,
                                             input dao_pkg::dao_top_st_t s,
                                             input logic [6:0] stat,
                                             input logic [26:0] res);
        logic [31:0] d;
        d = 32'h0;
        unique case (a)
            `DAO_OFF_CTRL: d = {30'h0, s.ctrl};
            `DAO_OFF_STATUS: d = {25'h0, stat};
            `DAO_OFF_RESULT: d = {5'h0, res};
            `DAO_OFF_INT_STAT: d = {28'h0, s.int_stat};
            `DAO_OFF_INT_EN: d = {28'h0, s.int_en};
            `DAO_OFF_COUNT: d = {s.cnt_b, s.cnt_a};
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    // Channel wiring; format is registered so both channels switch on one edge
    assign ch_a.sample_clock = chan_a_sample_clock;
    assign ch_a.power_down_sel = chan_a_power_down_sel;
    assign ch_a.output_enable_n = chan_a_output_enable_n;
    assign ch_a.capture_en = st.ctrl[0];
    assign ch_a.twos = st.twos;
    assign ch_a.level = chan_a_level;

    assign ch_b.sample_clock = chan_b_sample_clock;
    assign ch_b.power_down_sel = chan_b_power_down_sel;
    assign ch_b.output_enable_n = chan_b_output_enable_n;
    assign ch_b.capture_en = st.ctrl[1];
    assign ch_b.twos = st.twos;
    assign ch_b.level = chan_b_level;

    dao_chan u_chan_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .ch(ch_a.chan)
    );

    dao_chan u_chan_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .ch(ch_b.chan)
    );

    assign addr_ok = hsel & hready & htrans[1];

    // Events: bit0 A new result, bit1 B new result, bit2 A overrange, bit3 B overrange
    assign events = {ch_b.new_result & ch_b.range_flag,
                     ch_a.new_result & ch_a.range_flag,
                     ch_b.new_result,
                     ch_a.new_result};

    assign clr = (st.wr_pend && st.wr_addr == `DAO_OFF_INT_CLR) ? hwdata[3:0] : 4'h0;

    always_comb begin
        next_st = st;

        {next_st.twos, next_st.stab} = dao_fmt_decode(format_level);

        // Bus steering; the drive of a bus follows the channel routed onto it
        if (bus_steer) begin
            next_st.bus_a_result = ch_a.result;
            next_st.bus_a_flag = ch_a.range_flag;
            next_st.bus_a_oe_n = ch_a.hiz;
            next_st.bus_b_result = ch_b.result;
            next_st.bus_b_flag = ch_b.range_flag;
            next_st.bus_b_oe_n = ch_b.hiz;
        end else begin
            next_st.bus_a_result = ch_b.result;
            next_st.bus_a_flag = ch_b.range_flag;
            next_st.bus_a_oe_n = ch_b.hiz;
            next_st.bus_b_result = ch_a.result;
            next_st.bus_b_flag = ch_a.range_flag;
            next_st.bus_b_oe_n = ch_a.hiz;
        end

        // Data phase of a write: zero wait states, always OKAY
        if (st.wr_pend) begin
            unique case (st.wr_addr)
                `DAO_OFF_CTRL: next_st.ctrl = hwdata[1:0];
                `DAO_OFF_INT_EN: next_st.int_en = hwdata[3:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end

        // A new event in the clearing cycle stays set
        next_st.int_stat = (st.int_stat & ~clr) | events;

        if (ch_a.new_result) begin
            next_st.cnt_a = st.cnt_a + 16'h1;
        end
        if (ch_b.new_result) begin
            next_st.cnt_b = st.cnt_b + 16'h1;
        end

        // Read data is fetched in the address phase so it stands in the data phase
        next_st.wr_pend = addr_ok & hwrite;
        if (addr_ok) begin
            next_st.wr_addr = haddr[7:0];
        end
        if (addr_ok && !hwrite) begin
            next_st.hrdata = dao_read(haddr[7:0], st,
                                      {bus_steer, st.twos, st.stab, ch_b.mode, ch_a.mode},
                                      {ch_b.range_flag, 5'h0, ch_b.result,
                                       ch_a.range_flag, ch_a.result});
        end

        next_st.irq = |(next_st.int_stat & next_st.int_en);
        next_st.hreadyout = 1'b1;
        next_st.hresp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.ctrl <= `DAO_CTRL_RST;
            st.int_en <= `DAO_INT_EN_RST;
            st.bus_a_oe_n <= 1'b1;
            st.bus_b_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = st.hreadyout;
    assign hresp = st.hresp;
    assign hrdata = st.hrdata;
    assign irq = st.irq;
    assign bus_a_result = st.bus_a_result;
    assign chan_a_range_flag = st.bus_a_flag;
    assign bus_a_oe_n = st.bus_a_oe_n;
    assign bus_b_result = st.bus_b_result;
    assign chan_b_range_flag = st.bus_b_flag;
    assign bus_b_oe_n = st.bus_b_oe_n;
    assign stabilizer_on = st.stab;

endmodule

`default_nettype wire

/* tb/dao_capture.sv */
// Capture model that reads one shared result bus by sample clock phase
`timescale 1ns/1ps
`default_nettype none

module dao_capture (
    input wire logic hclk,
    input wire logic share_clock,
    input wire logic [9:0] bus_result,
    input wire logic bus_flag,
    input wire logic bus_oe_n,
    output logic [10:0] word_high,
    output logic [10:0] word_low
);
    logic prev;

    // Take the word at the end of a phase, when the bus has settled
    always_ff @(posedge hclk) begin
        prev <= share_clock;
        if (!bus_oe_n && prev && !share_clock) begin
            word_high <= {bus_flag, bus_result};
        end
        if (!bus_oe_n && !prev && share_clock) begin
            word_low <= {bus_flag, bus_result};
        end
    end
endmodule

`default_nettype wire

/* tb/dao_top_sva.sv */
// Assertions on the pins of the dual converter output block
`timescale 1ns/1ps
`default_nettype none

module dao_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic chan_a_sample_clock,
    input wire logic chan_b_sample_clock,
    input wire logic chan_a_power_down_sel,
    input wire logic chan_b_power_down_sel,
    input wire logic chan_a_output_enable_n,
    input wire logic chan_b_output_enable_n,
    input wire logic bus_steer,
    input wire logic [1:0] format_level,
    input wire logic [9:0] bus_a_result,
    input wire logic bus_a_oe_n,
    input wire logic bus_b_oe_n,
    input wire logic stabilizer_on
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Pins pass the mode register and the output register before the bus
    sequence s_a_on;
        (bus_steer && !chan_a_power_down_sel && !chan_a_output_enable_n)[*3];
    endsequence
    sequence s_b_on;
        (bus_steer && !chan_b_power_down_sel && !chan_b_output_enable_n)[*3];
    endsequence
    sequence s_a_off;
        (bus_steer && (chan_a_power_down_sel || chan_a_output_enable_n))[*3];
    endsequence
    sequence s_b_off;
        (bus_steer && (chan_b_power_down_sel || chan_b_output_enable_n))[*3];
    endsequence
    sequence s_b_on_a;
        (!bus_steer && !chan_b_power_down_sel && !chan_b_output_enable_n)[*3];
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_a_drive: assert property (s_a_on |-> !bus_a_oe_n)
        else $error("bus a not driven in normal mode");
    a_b_drive: assert property (s_b_on |-> !bus_b_oe_n)
        else $error("bus b not driven in normal mode");
    a_a_float: assert property (s_a_off |-> bus_a_oe_n)
        else $error("bus a driven while disabled");
    a_b_float: assert property (s_b_off |-> bus_b_oe_n)
        else $error("bus b driven while disabled");
    a_swap_drive: assert property (s_b_on_a |-> !bus_a_oe_n)
        else $error("swapped bus a not driven by channel b");
    a_stab_format: assert property (
        1'b1 |=> stabilizer_on == ($past(format_level) inside {2'h1, 2'h2}))
        else $error("stabilizer does not follow format pin");
    // A word only moves after a sample clock rise or a steering change
    a_word_hold: assert property ($changed(bus_a_result) |->
        ($past(chan_a_sample_clock, 2) && !$past(chan_a_sample_clock, 3)) ||
        ($past(chan_b_sample_clock, 2) && !$past(chan_b_sample_clock, 3)) ||
        ($past(bus_steer) != $past(bus_steer, 2)) ||
        ($past(bus_steer, 2) != $past(bus_steer, 3)))
        else $error("bus a word changed without a conversion");
endmodule

bind dao_top dao_top_sva i_sva (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .chan_a_sample_clock(chan_a_sample_clock),
    .chan_b_sample_clock(chan_b_sample_clock),
    .chan_a_power_down_sel(chan_a_power_down_sel),
    .chan_b_power_down_sel(chan_b_power_down_sel),
    .chan_a_output_enable_n(chan_a_output_enable_n),
    .chan_b_output_enable_n(chan_b_output_enable_n),
    .bus_steer(bus_steer),
    .format_level(format_level),
    .bus_a_result(bus_a_result),
    .bus_a_oe_n(bus_a_oe_n),
    .bus_b_oe_n(bus_b_oe_n),
    .stabilizer_on(stabilizer_on)
);

`default_nettype wire

/* tb/test_dual_adc_output_control.sv */
// Self-checking bench of the dual converter output block
`timescale 1ns/1ps
`default_nettype none
`include "dao_regs.svh"

module test_dual_adc_output_control;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, format_level;
    logic [2:0] hsize;
    logic chan_a_sample_clock, chan_b_sample_clock, bus_steer, stabilizer_on;
    logic [11:0] chan_a_level, chan_b_level;
    logic chan_a_power_down_sel, chan_b_power_down_sel;
    logic chan_a_output_enable_n, chan_b_output_enable_n;
    logic [9:0] bus_a_result, bus_b_result;
    logic chan_a_range_flag, chan_b_range_flag, bus_a_oe_n, bus_b_oe_n;
    logic [10:0] cap_hi, cap_lo;
    int n_fail, compares;
    int tbl[12] = '{700, -700, 511, -512, 0, 1, -1, 100, -300, 250, 37, -5};

    assign hready = hreadyout;

    dao_top i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .irq(irq),
        .chan_a_sample_clock(chan_a_sample_clock),
        .chan_b_sample_clock(chan_b_sample_clock),
        .chan_a_level(chan_a_level),
        .chan_b_level(chan_b_level),
        .chan_a_power_down_sel(chan_a_power_down_sel),
        .chan_b_power_down_sel(chan_b_power_down_sel),
        .chan_a_output_enable_n(chan_a_output_enable_n),
        .chan_b_output_enable_n(chan_b_output_enable_n),
        .bus_steer(bus_steer),
        .format_level(format_level),
        .bus_a_result(bus_a_result),
        .chan_a_range_flag(chan_a_range_flag),
        .bus_a_oe_n(bus_a_oe_n),
        .bus_b_result(bus_b_result),
        .chan_b_range_flag(chan_b_range_flag),
        .bus_b_oe_n(bus_b_oe_n),
        .stabilizer_on(stabilizer_on)
    );

    dao_capture i_cap (.hclk(hclk), .share_clock(chan_a_sample_clock),
        .bus_result(bus_a_result), .bus_flag(chan_a_range_flag),
        .bus_oe_n(bus_a_oe_n), .word_high(cap_hi), .word_low(cap_lo));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task report_and_stop();
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single AHB-Lite word transfer; always leaves one idle cycle first
    // Waits only on hready; a hung slave is caught by the watchdog
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // Clamp to the span, flag the overrange, straight binary flips the sign bit
    function automatic logic [10:0] code(input int v, input logic tw);
        int c;
        logic [9:0] r;
        c = v > 511 ? 511 : (v < -512 ? -512 : v);
        r = c[9:0];
        r[9] = tw ? r[9] : ~r[9];
        return {c != v, r};
    endfunction

    task run(input int n, input int half, input int step, input logic s, input logic tw,
             input logic tie);
        logic [10:0] ea, eb;
        for (int i = 0; i < n; i++) begin
            chan_a_level <= 12'(tbl[(i * step) % 12]);
            chan_b_level <= 12'(tbl[(i * step + 1) % 12]);
            {chan_a_sample_clock, chan_b_sample_clock} <= 2'h0;
            bus_steer <= tie ? 1'b0 : s;
            repeat (half) @(posedge hclk);
            {chan_a_sample_clock, chan_b_sample_clock} <= 2'h3;
            bus_steer <= tie ? 1'b1 : s;
            repeat (half) @(posedge hclk);
            #1;
            if (!tie && i >= 6) begin
                ea = code(tbl[(i - 6) % 12], tw);
                eb = code(tbl[(i - 5) % 12], tw);
                chk("bus_a", 32'(s ? ea : eb), 32'({chan_a_range_flag, bus_a_result}));
                chk("bus_b", 32'(s ? eb : ea), 32'({chan_b_range_flag, bus_b_result}));
            end
        end
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {chan_a_sample_clock, chan_b_sample_clock, chan_a_level, chan_b_level} = '0;
        {chan_a_power_down_sel, chan_a_output_enable_n} = 2'h3;
        {chan_b_power_down_sel, chan_b_output_enable_n} = 2'h3;
        bus_steer = 1'b1;
        format_level = 2'h3;
        n_fail = 0;
        compares = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `DAO_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        bus(1'b0, `DAO_OFF_INT_EN, 32'h0);
        chk("int_en", 32'h0, rd);
        // Walk all four power mode pin pairs on both channels
        for (int m = 0; m < 4; m++) begin
            {chan_a_power_down_sel, chan_a_output_enable_n} <= 2'(m);
            {chan_b_power_down_sel, chan_b_output_enable_n} <= 2'(m);
            bus(1'b0, `DAO_OFF_STATUS, 32'h0);
            #1;
            chk("mode", 32'({2'(m ^ (m >> 1)), 2'(m ^ (m >> 1))}), 32'(rd[3:0]));
            chk("oe", 32'({m != 0, m != 0}), 32'({bus_a_oe_n, bus_b_oe_n}));
        end
        for (int f = 0; f < 4; f++) begin
            format_level <= 2'(f);
            bus(1'b0, `DAO_OFF_STATUS, 32'h0);
            #1;
            chk("stab", 32'(f == 1 || f == 2), 32'(stabilizer_on));
            chk("twos", 32'(f >= 2), 32'(rd[5]));
        end
        {chan_a_power_down_sel, chan_a_output_enable_n} <= 2'h0;
        {chan_b_power_down_sel, chan_b_output_enable_n} <= 2'h0;
        run(12, 2, 1, 1'b1, 1'b1, 1'b0);
        format_level <= 2'h0;
        run(12, 2, 1, 1'b0, 1'b0, 1'b0);
        format_level <= 2'h3;
        run(12, 4, 0, 1'b1, 1'b1, 1'b1);
        {chan_a_sample_clock, chan_b_sample_clock, bus_steer} <= 3'h0;
        repeat (5) @(posedge hclk);
        #1;
        chk("shared_a", 32'(code(tbl[0], 1'b1)), 32'(cap_hi));
        chk("shared_b", 32'(code(tbl[1], 1'b1)), 32'(cap_lo));
        // Events stay masked until enabled, then clear bit 0 alone and the other three together
        chk("irq", 32'h0, 32'(irq));
        bus(1'b0, `DAO_OFF_INT_STAT, 32'h0);
        chk("int_stat", 32'hf, rd);
        bus(1'b1, `DAO_OFF_INT_EN, 32'h1);
        bus(1'b0, `DAO_OFF_INT_EN, 32'h0);
        #1;
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, `DAO_OFF_INT_CLR, 32'h1);
        bus(1'b0, `DAO_OFF_INT_STAT, 32'h0);
        #1;
        chk("int_stat", 32'he, rd);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b1, `DAO_OFF_INT_CLR, 32'he);
        bus(1'b0, `DAO_OFF_INT_STAT, 32'h0);
        chk("int_stat", 32'h0, rd);
        bus(1'b0, `DAO_OFF_INT_CLR, 32'h0);
        chk("int_clr", 32'h0, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        // 36 rises per channel, the first six only fill the pipeline
        bus(1'b0, `DAO_OFF_COUNT, 32'h0);
        chk("count", 32'h001e001e, rd);
        // Channel words: B flag, B -512 clamped, A flag, A 511 clamped, two's complement
        bus(1'b0, `DAO_OFF_RESULT, 32'h0);
        chk("result", 32'h041005ff, rd);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        report_and_stop();
    end
endmodule

`default_nettype wire
